// >>> hdl/spi_sram_secure_access.v
// Purpose: spi slave command engine of a serial sram with checksum-protected block access
// Assumes: spi mode 0 pins sampled by i_clk, sck at most i_clk/8; array sits outside
// Notes:
`timescale 1ns/1ps
`include "spi_sram_map.vh"
module spi_sram_secure_access #(
   parameter ADDR_W = `ADDR_BITS,
   parameter PAGE_W = `PAGE_BITS
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_cs_n,
   input wire i_sck,
   input wire i_si,
   output wire o_so,
   output wire o_so_oe,
   input wire i_page_rollover_bit,
   input wire i_transfer_busy_flag,
   input wire i_restore,
   input wire [ADDR_W-1:0] i_restore_last_write_addr,
   input wire [15:0] i_restore_user_space_value,
   output wire o_write_enable_latch,
   output wire o_secure_write_fail_flag,
   output wire [ADDR_W-1:0] o_last_write_addr_reg,
   output wire [15:0] o_user_space_value,
   output wire [ADDR_W-1:0] o_mem_rd_addr,
   input wire [7:0] i_mem_rd_data,
   output wire o_mem_wr_valid,
   output wire [ADDR_W-1:0] o_mem_wr_addr,
   output wire [7:0] o_mem_wr_data,
   input wire i_mem_wr_ready
);

   localparam ST_CMD = 2'd0;
   localparam ST_ADDR = 2'd1;
   localparam ST_DATA = 2'd2;
   localparam ST_SKIP = 2'd3;
   localparam [ADDR_W-1:0] ONE_A = {{(ADDR_W-1){1'b0}}, 1'b1};

   function [15:0] crc_bit;
      input [15:0] c;
      input b;
      begin
         crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
      end
   endfunction

   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      integer k;
      begin
         crc_byte = c;
         for (k = 7; k >= 0; k = k - 1) begin
            crc_byte = crc_bit(crc_byte, d[k]);
         end
      end
   endfunction

   // starts from the preset; stuff bits above the array never enter
   function [15:0] crc_addr;
      input [ADDR_W-1:0] a;
      integer k;
      begin
         crc_addr = `CRC_PRESET;
         for (k = ADDR_W - 1; k >= 0; k = k - 1) begin
            crc_addr = crc_bit(crc_addr, a[k]);
         end
      end
   endfunction

   function [ADDR_W-1:0] next_addr;
      input [ADDR_W-1:0] a;
      input roll;
      reg [PAGE_W-1:0] lo;
      begin
         lo = a[PAGE_W-1:0] + ONE_A[PAGE_W-1:0];
         next_addr = roll ? a + ONE_A : {a[ADDR_W-1:PAGE_W], lo};
      end
   endfunction

   reg cs_s1, cs_s2, cs_s3;
   reg sck_s1, sck_s2, sck_s3;
   reg si_s1, si_s2;
   reg [1:0] st_q;
   reg [7:0] op_q;
   reg [2:0] bit_q;
   reg [6:0] byte_q;
   reg [7:0] sh_q;
   reg [7:0] tmp_q;
   reg [7:0] so_q;
   reg so_oe_q;
   reg [ADDR_W-1:0] addr_q;
   reg [ADDR_W-1:0] rd_addr_q;
   reg [15:0] crc_q;
   reg [15:0] rx_crc_q;
   reg write_enable_cmd_q;
   reg write_enable_latch_q;
   reg swf_q;
   reg [ADDR_W-1:0] lwa_q;
   reg [15:0] usr_q;
   reg pend_q;
   reg [ADDR_W-1:0] pend_addr_q;
   reg [7:0] pend_data_q;
   reg cmt_q;
   reg [5:0] cmt_idx_q;
   reg [ADDR_W-1:0] cmt_base_q;
   reg [7:0] sbuf_q [0:63];
   integer i;

   // levels come from the second stage; cs and sck edges compare the second and third stages
   wire sel = ~cs_s2;
   wire cs_rise = cs_s2 & ~cs_s3;
   wire sck_rise = sel & sck_s2 & ~sck_s3;
   wire sck_fall = sel & ~sck_s2 & sck_s3;
   wire [7:0] rx_byte = {sh_q[6:0], si_s2};
   wire byte_done = sck_rise & (bit_q == 3'h7);
   wire rd_op = (op_q == `OP_READ) | (op_q == `OP_RD_LWA) | (op_q == `OP_USR_RD) | (op_q == `OP_SEC_RD);
   wire [15:0] lwa_word = {{(16-ADDR_W){1'b0}}, lwa_q};
   wire [15:0] addr_word = {tmp_q, rx_byte};
   wire [6:0] byte_inc = (byte_q == `BYTE_CNT_MAX) ? byte_q : byte_q + 7'h01;

   // one write path: a pending spi byte beats the secure block walker
   wire push_valid = pend_q | cmt_q;
   wire [ADDR_W-1:0] push_addr = pend_q ? pend_addr_q : (cmt_base_q | {{(ADDR_W-6){1'b0}}, cmt_idx_q});
   wire [7:0] push_data = pend_q ? pend_data_q : sbuf_q[cmt_idx_q];
   wire push_ready;
   wire push_ok = push_valid & push_ready;

   assign o_so = so_q[7];
   assign o_so_oe = so_oe_q;
   assign o_write_enable_latch = write_enable_latch_q;
   assign o_secure_write_fail_flag = swf_q;
   assign o_last_write_addr_reg = lwa_q;
   assign o_user_space_value = usr_q;
   assign o_mem_rd_addr = rd_addr_q;

   wr_skid_buffer #(
      .WIDTH(ADDR_W + 8)
   ) u_wr_buf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_in_valid(push_valid),
      .o_in_ready(push_ready),
      .i_in_data({push_addr, push_data}),
      .o_out_valid(o_mem_wr_valid),
      .i_out_ready(i_mem_wr_ready),
      .o_out_data({o_mem_wr_addr, o_mem_wr_data})
   );

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         si_s1 <= 1'b0;
         si_s2 <= 1'b0;
         st_q <= ST_CMD;
         op_q <= `BYTE_RESET;
         bit_q <= 3'h0;
         byte_q <= 7'h00;
         sh_q <= `BYTE_RESET;
         tmp_q <= `BYTE_RESET;
         so_q <= `BYTE_RESET;
         so_oe_q <= 1'b0;
         addr_q <= {ADDR_W{1'b0}};
         rd_addr_q <= {ADDR_W{1'b0}};
         crc_q <= `CRC_PRESET;
         rx_crc_q <= 16'h0000;
         write_enable_cmd_q <= 1'b0;
         write_enable_latch_q <= 1'b0;
         swf_q <= 1'b0;
         lwa_q <= `LWA_RESET;
         usr_q <= `USR_RESET;
         pend_q <= 1'b0;
         pend_addr_q <= {ADDR_W{1'b0}};
         pend_data_q <= `BYTE_RESET;
         cmt_q <= 1'b0;
         cmt_idx_q <= 6'h00;
         cmt_base_q <= {ADDR_W{1'b0}};
         for (i = 0; i < 64; i = i + 1) begin
            sbuf_q[i] <= `BYTE_RESET;
         end
      end else begin
         cs_s1 <= i_cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         sck_s1 <= i_sck;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         si_s1 <= i_si;
         si_s2 <= si_s1;

         // reload of the backed-up values; a commit in the same cycle wins
         if (i_restore) begin
            lwa_q <= i_restore_last_write_addr;
            usr_q <= i_restore_user_space_value;
         end
         if (push_ok) begin
            lwa_q <= push_addr;
            if (pend_q) begin
               pend_q <= 1'b0;
            end else begin
               cmt_idx_q <= cmt_idx_q + 6'h01;
               if (cmt_idx_q == `SEC_LAST_IDX) begin
                  cmt_q <= 1'b0;
               end
            end
         end

         if (cs_s2) begin
            st_q <= ST_CMD;
            bit_q <= 3'h0;
            byte_q <= 7'h00;
            so_oe_q <= 1'b0;
            op_q <= `BYTE_RESET;
         end

         if (cs_rise) begin
            write_enable_cmd_q <= 1'b0;
            if (write_enable_cmd_q) begin
               write_enable_latch_q <= 1'b1;
            end
            if ((op_q == `OP_WRITE) || (op_q == `OP_USR_WR)) begin
               write_enable_latch_q <= 1'b0;
            end
            if (op_q == `OP_SEC_WR) begin
               write_enable_latch_q <= 1'b0;
               if ((byte_q == `SEC_FRAME_END) && (rx_crc_q == crc_q)) begin
                  // a new block arriving before the walker ends would be torn
                  cmt_q <= 1'b1;
                  cmt_idx_q <= 6'h00;
                  cmt_base_q <= addr_q;
               end else begin
                  swf_q <= 1'b1;
               end
            end
         end

         if (sck_rise) begin
            sh_q <= rx_byte;
            bit_q <= bit_q + 3'h1;
            write_enable_cmd_q <= byte_done && (st_q == ST_CMD) && (rx_byte == `OP_WRITE_EN);
         end

         if (byte_done) begin
            case (st_q)
               ST_CMD: begin
                  op_q <= rx_byte;
                  byte_q <= 7'h00;
                  st_q <= ST_SKIP;
                  if (i_transfer_busy_flag) begin
                     op_q <= `BYTE_RESET;
                  end else if ((rx_byte == `OP_READ) || (rx_byte == `OP_SEC_RD)) begin
                     st_q <= ST_ADDR;
                  end else if ((rx_byte == `OP_RD_LWA) || (rx_byte == `OP_USR_RD)) begin
                     st_q <= ST_DATA;
                  end else if ((rx_byte == `OP_WRITE) || (rx_byte == `OP_SEC_WR) || (rx_byte == `OP_USR_WR)) begin
                     if (!write_enable_latch_q) begin
                        op_q <= `BYTE_RESET;
                     end else begin
                        st_q <= (rx_byte == `OP_USR_WR) ? ST_DATA : ST_ADDR;
                        if (rx_byte == `OP_SEC_WR) begin
                           swf_q <= 1'b0;
                        end
                     end
                  end
               end
               ST_ADDR: begin
                  tmp_q <= rx_byte;
                  byte_q <= byte_inc;
                  if (byte_q == 7'h01) begin
                     addr_q <= addr_word[ADDR_W-1:0];
                     rd_addr_q <= addr_word[ADDR_W-1:0];
                     crc_q <= crc_addr(addr_word[ADDR_W-1:0]);
                     byte_q <= 7'h00;
                     st_q <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  if (op_q == `OP_WRITE) begin
                     pend_q <= 1'b1;
                     pend_addr_q <= addr_q;
                     pend_data_q <= rx_byte;
                     addr_q <= next_addr(addr_q, i_page_rollover_bit);
                  end else if (op_q == `OP_USR_WR) begin
                     tmp_q <= rx_byte;
                     byte_q <= byte_inc;
                     if (byte_q == 7'h01) begin
                        usr_q <= addr_word;
                        st_q <= ST_SKIP;
                     end
                  end else if (op_q == `OP_SEC_WR) begin
                     byte_q <= byte_inc;
                     if (byte_q < `SEC_CRC_HI) begin
                        sbuf_q[byte_q[5:0]] <= rx_byte;
                        crc_q <= crc_byte(crc_q, rx_byte);
                     end else if (byte_q == `SEC_CRC_HI) begin
                        rx_crc_q[15:8] <= rx_byte;
                     end else if (byte_q == `SEC_CRC_LO) begin
                        rx_crc_q[7:0] <= rx_byte;
                     end
                  end
                  // read commands leave serial input unused here
               end
               default: begin
                  // ST_SKIP drops incoming bits until chip select rises
               end
            endcase
         end

         if (sck_fall && (st_q == ST_DATA) && rd_op) begin
            if (bit_q == 3'h0) begin
               byte_q <= byte_inc;
               so_oe_q <= 1'b1;
               case (op_q)
                  `OP_READ: begin
                     so_q <= i_mem_rd_data;
                     rd_addr_q <= rd_addr_q + ONE_A;
                  end
                  `OP_RD_LWA: begin
                     so_q <= (byte_q == 7'h00) ? lwa_word[15:8] : lwa_word[7:0];
                     so_oe_q <= (byte_q < 7'h02);
                  end
                  `OP_USR_RD: begin
                     so_q <= (byte_q == 7'h00) ? usr_q[15:8] : usr_q[7:0];
                     so_oe_q <= (byte_q < 7'h02);
                  end
                  `OP_SEC_RD: begin
                     if (byte_q < `SEC_CRC_HI) begin
                        so_q <= i_mem_rd_data;
                        crc_q <= crc_byte(crc_q, i_mem_rd_data);
                        rd_addr_q <= rd_addr_q + ONE_A;
                     end else if (byte_q == `SEC_CRC_HI) begin
                        so_q <= crc_q[15:8];
                     end else begin
                        so_q <= crc_q[7:0];
                        so_oe_q <= (byte_q == `SEC_CRC_LO);
                     end
                  end
                  default: begin
                     so_oe_q <= 1'b0;
                  end
               endcase
            end else begin
               so_q <= {so_q[6:0], 1'b0};
            end
         end
      end
   end
endmodule // spi_sram_secure_access

// >>> hdl/spi_sram_map.vh
// Purpose: constants of the serial sram command engine
// Assumes: included by bare name from the design files
// Notes: opcodes, widths, reset values and checksum figures live here
`ifndef SPI_SRAM_MAP_VH
`define SPI_SRAM_MAP_VH

// opcodes
`define OP_WRITE_EN 8'h06
`define OP_READ 8'h03
`define OP_WRITE 8'h02
`define OP_RD_LWA 8'h0A
`define OP_SEC_WR 8'h12
`define OP_SEC_RD 8'h13
`define OP_USR_WR 8'hC2
`define OP_USR_RD 8'hC3

// array geometry
`define ADDR_BITS 15
`define PAGE_BITS 6
`define SEC_LAST_IDX 6'h3F
`define SEC_CRC_HI 7'h40
`define SEC_CRC_LO 7'h41
`define SEC_FRAME_END 7'h42
`define BYTE_CNT_MAX 7'h7F

// checksum
`define CRC_PRESET 16'hFFFF
`define CRC_POLY 16'h1021

// reset values
`define LWA_RESET 15'h0000
`define USR_RESET 16'h0000
`define BYTE_RESET 8'h00

`endif

// >>> hdl/wr_skid_buffer.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-high reset
// Notes: output side comes straight from the head register
`timescale 1ns/1ps
module wr_skid_buffer #(
   parameter WIDTH = 23
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg head_valid_q;
   reg tail_valid_q;
   reg [WIDTH-1:0] head_q;
   reg [WIDTH-1:0] tail_q;
   wire pop = head_valid_q & i_out_ready;
   wire push = i_in_valid & ~tail_valid_q;

   assign o_in_ready = ~tail_valid_q;
   assign o_out_valid = head_valid_q;
   assign o_out_data = head_q;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         head_valid_q <= 1'b0;
         tail_valid_q <= 1'b0;
         head_q <= {WIDTH{1'b0}};
         tail_q <= {WIDTH{1'b0}};
      end else if (pop && tail_valid_q) begin
         // no push possible here: ready is low while the tail is full
         head_q <= tail_q;
         tail_valid_q <= 1'b0;
      end else if (pop) begin
         if (push) begin
            head_q <= i_in_data;
         end else begin
            head_valid_q <= 1'b0;
         end
      end else if (push) begin
         if (!head_valid_q) begin
            head_q <= i_in_data;
            head_valid_q <= 1'b1;
         end else begin
            tail_q <= i_in_data;
            tail_valid_q <= 1'b1;
         end
      end
   end
endmodule // wr_skid_buffer

// >>> bench/spi_sram_secure_access_monitor.sv
// Purpose: port-level checks of the serial sram command engine
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to every instance of the top module at the foot of this file
`timescale 1ns/1ps
module spi_sram_secure_access_monitor #(
   parameter ADDR_W = 15
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_cs_n,
   input wire o_so_oe,
   input wire i_restore,
   input wire [ADDR_W-1:0] i_restore_last_write_addr,
   input wire [15:0] i_restore_user_space_value,
   input wire o_write_enable_latch,
   input wire o_secure_write_fail_flag,
   input wire [ADDR_W-1:0] o_last_write_addr_reg,
   input wire [15:0] o_user_space_value,
   input wire o_mem_wr_valid,
   input wire [ADDR_W-1:0] o_mem_wr_addr,
   input wire [7:0] o_mem_wr_data,
   input wire i_mem_wr_ready
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_so_released: assert property (i_cs_n [*6] |-> !o_so_oe)
      else $error("serial out driven while deselected");
   a_latch_set_idle: assert property ($rose(o_write_enable_latch) |-> i_cs_n)
      else $error("write latch set inside a frame");
   a_latch_clr_idle: assert property ($fell(o_write_enable_latch) |-> i_cs_n)
      else $error("write latch cleared inside a frame");
   a_fail_set_idle: assert property ($rose(o_secure_write_fail_flag) |-> i_cs_n)
      else $error("fail flag set before frame end");
   a_fail_clr_frame: assert property ($fell(o_secure_write_fail_flag) |-> !i_cs_n)
      else $error("fail flag cleared outside a secure write");
   a_wr_stall_hold: assert property (o_mem_wr_valid && !i_mem_wr_ready |=>
      o_mem_wr_valid && $stable(o_mem_wr_addr) && $stable(o_mem_wr_data))
      else $error("write request changed while stalled");
   a_wr_addr_step: assert property ((o_mem_wr_valid && i_mem_wr_ready) ##1 o_mem_wr_valid
      |-> o_mem_wr_addr != $past(o_mem_wr_addr))
      else $error("write address did not advance");
   a_lwa_last_commit: assert property ($fell(o_mem_wr_valid) |->
      o_last_write_addr_reg == $past(o_mem_wr_addr))
      else $error("last written address differs from last commit");
   a_restore_load: assert property (i_restore && i_cs_n && !o_mem_wr_valid |=>
      o_user_space_value == $past(i_restore_user_space_value)
      && o_last_write_addr_reg == $past(i_restore_last_write_addr))
      else $error("restore values not loaded");
endmodule // spi_sram_secure_access_monitor
bind spi_sram_secure_access spi_sram_secure_access_monitor #(.ADDR_W(ADDR_W)) u_spi_sram_secure_access_monitor (
   .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_so_oe(o_so_oe), .i_restore(i_restore),
   .i_restore_last_write_addr(i_restore_last_write_addr), .i_restore_user_space_value(i_restore_user_space_value),
   .o_write_enable_latch(o_write_enable_latch), .o_secure_write_fail_flag(o_secure_write_fail_flag),
   .o_last_write_addr_reg(o_last_write_addr_reg), .o_user_space_value(o_user_space_value),
   .o_mem_wr_valid(o_mem_wr_valid), .o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data),
   .i_mem_wr_ready(i_mem_wr_ready)
);

// >>> bench/spi_master_model.sv
// Purpose: spi mode 0 master driving chip select, clock and data in
// Assumes: sck period of eight system clocks, all changes just after a rising edge
// Notes: sck stands low between frames; si flips after a frame as nobody holds it
`timescale 1ns/1ps
module spi_master_model (
   input wire i_clk,
   input wire i_so,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si
);
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end
   task automatic begin_frame();
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
   // bits go out msb first, returned data is taken late in the high phase
   task automatic xfer(input logic [7:0] o, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         o_sck <= 1'b0;
         o_si <= o[7-i];
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (3) @(posedge i_clk);
         r = {r[6:0], i_so};
      end
   endtask
   // idle of eight clocks after a frame lets queued spi byte writes land; the secure block walker takes longer
   task automatic end_frame();
      @(posedge i_clk);
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
      repeat (8) @(posedge i_clk);
   endtask
endmodule // spi_master_model

// >>> bench/testbench.sv
// Purpose: command sequences against the serial sram command engine
// Assumes: array modelled here, write port stalls one cycle in three
// Notes: expected array contents derive from the fill pattern and written data
`timescale 1ns/1ps
module testbench;
   logic i_clk, i_rst, i_cs_n, i_sck, i_si, i_page_rollover_bit, i_transfer_busy_flag, i_restore;
   logic [14:0] i_restore_last_write_addr;
   logic [15:0] i_restore_user_space_value;
   logic [7:0] i_mem_rd_data, rx;
   logic i_mem_wr_ready;
   wire o_so, o_so_oe, o_write_enable_latch, o_secure_write_fail_flag, o_mem_wr_valid;
   wire [14:0] o_last_write_addr_reg, o_mem_rd_addr, o_mem_wr_addr;
   wire [15:0] o_user_space_value;
   wire [7:0] o_mem_wr_data;
   wire so_line = o_so_oe ? o_so : 1'bz;
   logic [7:0] mem [0:32767];
   int fails = 0, total_checks = 0, cyc = 0;
   spi_sram_secure_access u_spi_sram_secure_access (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
      .i_sck(i_sck), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_page_rollover_bit(i_page_rollover_bit),
      .i_transfer_busy_flag(i_transfer_busy_flag), .i_restore(i_restore),
      .i_restore_last_write_addr(i_restore_last_write_addr), .i_restore_user_space_value(i_restore_user_space_value),
      .o_write_enable_latch(o_write_enable_latch), .o_secure_write_fail_flag(o_secure_write_fail_flag),
      .o_last_write_addr_reg(o_last_write_addr_reg), .o_user_space_value(o_user_space_value),
      .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_data(i_mem_rd_data), .o_mem_wr_valid(o_mem_wr_valid),
      .o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data), .i_mem_wr_ready(i_mem_wr_ready));
   spi_master_model u_spi_master_model (.i_clk(i_clk), .i_so(so_line), .o_cs_n(i_cs_n), .o_sck(i_sck),
      .o_si(i_si));
   always #20 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      i_mem_rd_data <= mem[o_mem_rd_addr];
      i_mem_wr_ready <= (cyc % 3) != 0;
      if (o_mem_wr_valid && i_mem_wr_ready) mem[o_mem_wr_addr] <= o_mem_wr_data;
      if (cyc == 60000) begin
         fails++;
         final_report();
      end
   end
   function automatic logic [7:0] pat(input logic [14:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   function automatic logic [7:0] dat(input int i);
      return 8'(i * 7 + 3);
   endfunction
   // checksum bit by bit, msb first, no final inversion
   function automatic logic [15:0] crcb(input logic [15:0] c, input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic sb(input logic [7:0] b);
      u_spi_master_model.xfer(b, 8, rx);
   endtask
   // reads drive a busy pattern on si, which the device has to ignore
   task automatic rd(input string nm, input logic [7:0] e);
      sb(8'hA5);
      chk(nm, {8'h00, rx}, {8'h00, e});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input int na);
      u_spi_master_model.begin_frame();
      sb(op);
      if (na > 0) sb(a[15:8]);
      if (na > 0) sb(a[7:0]);
   endtask
   task automatic send_write_enable();
      cmd(8'h06, 16'h0000, 0);
      u_spi_master_model.end_frame();
      chk("latch set", o_write_enable_latch, 1);
   endtask
   task automatic sec_wr(input logic [15:0] a, input logic bad);
      logic [15:0] c;
      c = crcb(16'hFFFF, a, 15);
      send_write_enable();
      cmd(8'h12, a, 2);
      for (int i = 0; i < 64; i++) begin
         sb(dat(i));
         c = crcb(c, {8'h00, dat(i)}, 8);
      end
      c = c ^ {15'h0000, bad};
      sb(c[15:8]);
      sb(c[7:0]);
      u_spi_master_model.end_frame();
      repeat (200) @(posedge i_clk);
      chk("latch after secure", o_write_enable_latch, 0);
      chk("fail flag", o_secure_write_fail_flag, {15'h0000, bad});
      chk("secure byte", mem[a[14:0] + 15'h0005], bad ? pat(a[14:0] + 15'h0005) : dat(5));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      logic [15:0] c;
      i_clk = 0;
      i_rst = 1;
      i_page_rollover_bit = 0;
      i_transfer_busy_flag = 0;
      i_restore = 0;
      i_restore_last_write_addr = 15'h0000;
      i_restore_user_space_value = 16'h0000;
      i_mem_rd_data = 8'h00;
      i_mem_wr_ready = 0;
      for (int a = 0; a < 32768; a++) mem[a] = pat(15'(a));
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk("reset latch", o_write_enable_latch, 0);
      chk("reset user", o_user_space_value, 16'h0000);
      cmd(8'h02, 16'h0010, 2);
      sb(8'hAA);
      u_spi_master_model.end_frame();
      repeat (16) @(posedge i_clk);
      chk("unlatched write", mem[16], pat(15'h0010));
      // store or recall in progress: the latch command still works, the write must not
      i_transfer_busy_flag <= 1'b1;
      send_write_enable();
      cmd(8'h02, 16'h0200, 2);
      sb(8'h77);
      u_spi_master_model.end_frame();
      i_transfer_busy_flag <= 1'b0;
      repeat (16) @(posedge i_clk);
      chk("busy write", mem[15'h0200], pat(15'h0200));
      $display("test write refusal done");
      send_write_enable();
      cmd(8'h02, 16'h007E, 2);
      sb(8'h11);
      sb(8'h22);
      sb(8'h33);
      u_spi_master_model.xfer(8'hEE, 4, rx);
      u_spi_master_model.end_frame();
      repeat (16) @(posedge i_clk);
      chk("page wrap", mem[15'h0040], 8'h33);
      chk("page end", {mem[15'h007E], mem[15'h007F]}, 16'h1122);
      chk("partial byte", mem[15'h0041], pat(15'h0041));
      chk("last addr", o_last_write_addr_reg, 16'h0040);
      chk("latch cleared", o_write_enable_latch, 0);
      i_page_rollover_bit <= 1'b1;
      send_write_enable();
      cmd(8'h02, 16'h00BF, 2);
      sb(8'h44);
      sb(8'h55);
      u_spi_master_model.end_frame();
      repeat (16) @(posedge i_clk);
      chk("page cross", {mem[15'h00BF], mem[15'h00C0]}, 16'h4455);
      $display("test array write done");
      cmd(8'h03, 16'hFFFF, 2);
      rd("read end", pat(15'h7FFF));
      rd("read wrap", pat(15'h0000));
      rd("read next", pat(15'h0001));
      u_spi_master_model.end_frame();
      cmd(8'h0A, 16'h0000, 0);
      rd("lwa hi", 8'h00);
      rd("lwa lo", 8'hC0);
      u_spi_master_model.end_frame();
      $display("test read done");
      @(posedge i_clk);
      i_restore <= 1'b1;
      i_restore_last_write_addr <= 15'h7234;
      i_restore_user_space_value <= 16'hBEEF;
      @(posedge i_clk);
      i_restore <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk("restore user", o_user_space_value, 16'hBEEF);
      cmd(8'h0A, 16'h0000, 0);
      rd("restored lwa hi", 8'h72);
      rd("restored lwa lo", 8'h34);
      u_spi_master_model.end_frame();
      send_write_enable();
      cmd(8'hC2, 16'h9C3E, 2);
      u_spi_master_model.end_frame();
      chk("user value", o_user_space_value, 16'h9C3E);
      cmd(8'hC3, 16'h0000, 0);
      rd("user hi", 8'h9C);
      rd("user lo", 8'h3E);
      u_spi_master_model.end_frame();
      $display("test user space done");
      sec_wr(16'h0080, 1'b1);
      sec_wr(16'h0080, 1'b0);
      sec_wr(16'h0100, 1'b1);
      c = crcb(16'hFFFF, 16'h0080, 15);
      cmd(8'h13, 16'h0080, 2);
      for (int i = 0; i < 64; i++) begin
         rd("secure data", dat(i));
         c = crcb(c, {8'h00, dat(i)}, 8);
      end
      rd("secure crc hi", c[15:8]);
      rd("secure crc lo", c[7:0]);
      u_spi_master_model.end_frame();
      chk("fail kept", o_secure_write_fail_flag, 1);
      $display("test secure done");
      final_report();
   end
endmodule // testbench
